// ### sim/host_model.sv
// Host controller model issuing register accesses on the request port
`timescale 1ns/100ps

module host_model
  import aux_route_pkg::*;
(
  // Clock
  input  wire logic i_clk,
  // Request toward the register bank
  output reg_req_t  o_req
);
  // Idle request from time zero
  initial o_req = '0;

  // One access: raised after an edge, taken at the next edge, then dropped
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_req <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge i_clk);
    o_req <= '0;
  endtask : access
endmodule : host_model

// ### sim/tb_aux_route_and_link_tuning_regs.sv
// Self-checking bench for the auxiliary routing and link tuning registers
`timescale 1ns/100ps
`include "aux_route_map.svh"

module tb_aux_route_and_link_tuning_regs
  import aux_route_pkg::*;
;
  // Short disconnect interval keeps the run brief
  localparam int P = 16;
  typedef struct { int sel; logic [63:0] val; } note_t;

  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  reg_req_t    req;
  logic [7:0]  o_reg_rdata;
  aux_matrix_t o_aux_connect;
  logic [15:0] o_hs_select;
  logic [15:0] o_term_connect;
  logic [15:0] o_eq_high;
  logic [1:0]  o_preemph_level;
  note_t       q[$];
  logic        look = 1'b0;
  logic [63:0] meas = '0;
  int          failures = 0;
  int          total_checks = 0;
  int          cyc = 0;

  // ---------------------------------------------------------------------------
  // Clock, instances, timeout
  // ---------------------------------------------------------------------------
  always #2.5 i_clk = ~i_clk;

  host_model i_host_model (.i_clk(i_clk), .o_req(req));

  aux_route_and_link_tuning_regs #(.TERM_PULSE_CYCLES(P)) i_aux_route_and_link_tuning_regs (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_req(req), .o_reg_rdata(o_reg_rdata),
    .o_aux_connect(o_aux_connect), .o_hs_select(o_hs_select), .o_term_connect(o_term_connect),
    .o_eq_high(o_eq_high), .o_preemph_level(o_preemph_level));

  // Cycle ceiling cuts a hang short
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_model.access(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    i_host_model.access(1'b0, a, 8'h00);
  endtask : rd

  // Notes an expectation and flags the monitor after outputs have settled
  task automatic note_exp(input int s, input logic [63:0] v);
    @(posedge i_clk);
    q.push_back('{s, v});
    look <= 1'b1;
    @(posedge i_clk);
    look <= 1'b0;
  endtask : note_exp

  // Register bit order B0-B3, A0-A3, C3-C0, D3-D0 into A0..D3 order
  function automatic logic [15:0] to_chan(input logic [15:0] r);
    logic [15:0] c;
    for (int i = 0; i < 4; i++) begin
      c[4+i]  = r[i];
      c[i]    = r[4+i];
      c[11-i] = r[8+i];
      c[15-i] = r[12+i];
    end
    return c;
  endfunction : to_chan

  // Write the high speed select, then count and merge the dropped cycles
  task automatic pulse_case(input logic [7:0] hs, input logic [15:0] exp_low);
    int          n;
    logic [15:0] lowv;
    n = 0;
    lowv = 16'hFFFF;
    wr(`ADDR_HS_MODES, hs);
    #1;
    repeat (P + 6) begin
      if (o_term_connect !== 16'hFFFF) n++;
      lowv &= o_term_connect;
      @(posedge i_clk);
      #1;
    end
    meas = {n[31:0], 16'h0000, lowv};
    note_exp(7, {((exp_low === 16'hFFFF) ? 32'h0 : 32'(P)), 16'h0000, exp_low});
  endtask : pulse_case

  // ---------------------------------------------------------------------------
  // Monitor: takes the oldest note whenever a result is flagged
  // ---------------------------------------------------------------------------
  always @(posedge i_clk) begin : monitor
    note_t       nt;
    logic [63:0] seen;
    if (look === 1'b1) begin
      nt = q.pop_front();
      case (nt.sel)
        0: seen = {56'h0, o_reg_rdata};
        1: seen = o_aux_connect;
        2: seen = {48'h0, o_aux_connect[0] | o_aux_connect[1] | o_aux_connect[2] | o_aux_connect[3]};
        3: seen = {48'h0, o_term_connect};
        4: seen = {48'h0, o_eq_high};
        5: seen = {62'h0, o_preemph_level};
        6: seen = {48'h0, o_hs_select};
        default: seen = meas;
      endcase
      check(seen, nt.val);
    end
  end

  // ---------------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------------
  initial begin
    aux_matrix_t m;
    logic [15:0] r;
    logic [7:0]  ra [8];
    logic [7:0]  rv [8];
    ra = '{`ADDR_AUX_MODES, `ADDR_RX_SETTINGS, `ADDR_TERM_PULSE_1, `ADDR_TERM_PULSE_2,
           `ADDR_RX_EQ_1, `ADDR_RX_EQ_2, `ADDR_TX_SETTINGS, 8'h20};
    rv = '{8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    void'($urandom(32'h5d58ca07));
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // Reset values, unmapped address reads zero
    for (int i = 0; i < 8; i++) begin
      rd(ra[i]);
      note_exp(0, {56'h0, rv[i]});
    end
    m = '0;
    for (int l = 0; l < 4; l++) m[l][l] = 1'b1;
    note_exp(1, m);
    note_exp(3, 64'hFFFF);
    // Dual mode over all sixteen codes, top bit ignored
    for (int s = 0; s < 16; s++) begin
      wr(`ADDR_AUX_MODES, 8'h50 | {4'h0, s[3:0]});
      m = '0;
      m[0][s[2:0]] = 1'b1;
      m[1][s[2:0]] = 1'b1;
      m[2][8 + s[2:0]] = 1'b1;
      m[3][8 + s[2:0]] = 1'b1;
      note_exp(1, m);
    end
    // Single mode: exactly one channel per code
    for (int s = 0; s < 16; s++) begin
      wr(`ADDR_AUX_MODES, 8'h60 | {4'h0, s[3:0]});
      note_exp(2, {48'h0, 16'h0001 << s[3:0]});
    end
    wr(`ADDR_AUX_MODES, 8'h75);
    note_exp(2, 64'h20);
    wr(`ADDR_AUX_MODES, 8'h05);
    note_exp(1, 64'h0);
    // Random equalizer pattern and read back
    r = 16'($urandom());
    wr(`ADDR_RX_EQ_1, r[7:0]);
    wr(`ADDR_RX_EQ_2, r[15:8]);
    note_exp(4, {48'h0, to_chan(r)});
    rd(`ADDR_RX_EQ_2);
    note_exp(0, {56'h0, r[15:8]});
    for (int p = 0; p < 4; p++) begin
      wr(`ADDR_TX_SETTINGS, {4'h0, p[1:0], 2'b00});
      note_exp(5, 64'(p));
    end
    wr(`ADDR_RX_SETTINGS, 8'h00);
    note_exp(3, 64'h0);
    wr(`ADDR_RX_SETTINGS, 8'h01);
    // Pulse bits: A0-A3 and C3 pulse, the rest stay connected
    wr(`ADDR_TERM_PULSE_1, 8'hF0);
    wr(`ADDR_TERM_PULSE_2, 8'h01);
    pulse_case(8'h40, 16'hFFF0);
    pulse_case(8'h41, 16'hFFF0);
    note_exp(6, 64'h00F0);
    pulse_case(8'h42, 16'hF7FF);
    pulse_case(8'h42, 16'hFFFF);
    // Illegal high speed mode keeps quad, readback shows the kept mode
    pulse_case(8'h72, 16'hFFFF);
    rd(`ADDR_HS_MODES);
    note_exp(0, 64'h42);
    // Dual and single high speed selections
    pulse_case(8'h55, 16'hFFFF);
    note_exp(6, 64'h0C00);
    pulse_case(8'h60, 16'hF7FE);
    note_exp(6, 64'h0001);
    // Status bit during and after an interval
    wr(`ADDR_HS_MODES, 8'h61);
    rd(`ADDR_STATUS);
    note_exp(0, 64'h01);
    repeat (P) @(posedge i_clk);
    rd(`ADDR_STATUS);
    note_exp(0, 64'h00);
    // Let the monitor take the last note before the verdict
    @(posedge i_clk);
    report_and_stop();
  end
endmodule : tb_aux_route_and_link_tuning_regs

// ### verilog/aux_route_and_link_tuning_regs.sv
// Auxiliary routing decode, termination pulsing and link tuning registers
//
// Notes on behaviour
// R01 - Dual mode ignores top select bit
// R02 - Dual low codes route A and C
// R03 - Dual high codes route B and D
// R04 - Single mode connects exactly one channel
// R05 - Single codes 0-7 pick A then B
// R06 - Single codes 8-15 pick C then D
// R07 - Termination enable gates all input terminations
// R08 - Pulse bit 0 keeps termination connected
// R09 - Pulse bit 1 disconnects 100 ms on change
// R10 - Pulse bits map B, A, C reversed, D reversed
// R11 - Equalization bit selects 6 or 12 dB
// R12 - Equalization bits use pulse bit order
// R13 - Pre-emphasis field drives every output channel
// R14 - Mode code 11 ignored, previous mode kept
// R15 - Auxiliary disable disconnects all common lines
// R16 - Shared counter times the disconnect interval
// R17 - Effective selection change starts channel pulses
`timescale 1ns/100ps
`include "aux_route_map.svh"

module aux_route_and_link_tuning_regs
  import aux_route_pkg::*;
#(
  parameter int TERM_PULSE_CYCLES = `TERM_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Register access from the serial bus engine
  input  wire reg_req_t    i_reg_req,
  output logic [7:0]       o_reg_rdata,
  // Auxiliary switch, channel index source*4 + channel
  output aux_matrix_t      o_aux_connect,
  // High speed receiver and transmitter controls, A0..D3 order
  output logic [15:0]      o_hs_select,
  output logic [15:0]      o_term_connect,
  output logic [15:0]      o_eq_high,
  output logic [1:0]       o_preemph_level
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------

  // Register bit that carries a channel, in A0..D3 order
  function automatic logic [15:0] to_channel_order(input logic [15:0] r);
    logic [15:0] c;
    c = 16'h0000;
    for (int n = 0; n < 4; n++) begin
      c[n]      = r[4 + n];
      c[4 + n]  = r[n];
      c[8 + n]  = r[11 - n];
      c[12 + n] = r[15 - n];
    end
    return c;
  endfunction : to_channel_order

  // Effective high speed channel selection
  function automatic logic [15:0] hs_mask(input logic [7:0] m);
    logic [15:0] k;
    k = 16'h0000;
    if (m[`FLD_MODE_EN]) begin
      case (bundle_mode_t'(m[`FLD_MODE_HI:`FLD_MODE_LO]))
        MODE_QUAD:   k[{m[1:0], 2'b00} +: 4] = 4'hF;
        MODE_DUAL:   k[{m[2:0], 1'b0} +: 2] = 2'h3;
        MODE_SINGLE: k[m[3:0]] = 1'b1;
        default:     k = 16'h0000;
      endcase
    end
    return k;
  endfunction : hs_mask

  // Auxiliary connection matrix
  function automatic aux_matrix_t aux_route(input logic [7:0] m);
    aux_matrix_t x;
    logic [3:0]  s;
    x = '0;
    s = m[`FLD_SEL_HI:`FLD_SEL_LO];
    if (m[`FLD_MODE_EN]) begin // R15
      case (bundle_mode_t'(m[`FLD_MODE_HI:`FLD_MODE_LO]))
        MODE_QUAD: begin
          for (int l = 0; l < 4; l++) begin
            x[l][{s[1:0], 2'b00} + 4'(l)] = 1'b1;
          end
        end
        MODE_DUAL: begin
          // Top bit dropped; bit 2 picks A/C or B/D pair R01
          x[0][{1'b0, s[2], s[1:0]}] = 1'b1; // R02
          x[1][{1'b0, s[2], s[1:0]}] = 1'b1; // R03
          x[2][{1'b1, s[2], s[1:0]}] = 1'b1; // R02
          x[3][{1'b1, s[2], s[1:0]}] = 1'b1; // R03
        end
        MODE_SINGLE: begin
          for (int l = 0; l < 4; l++) begin
            x[l][s] = 1'b1; // R04 R05 R06
          end
        end
        default: x = '0;
      endcase
    end
    return x;
  endfunction : aux_route

  // --------------------------------------------------------------------------
  // Registers and decode
  // --------------------------------------------------------------------------
  logic [7:0]   hs_modes_reg;
  logic [7:0]   hs_modes_next;
  logic [7:0]   aux_modes_reg;
  logic [7:0]   aux_modes_next;
  logic [7:0]   receiver_settings_reg;
  logic [7:0]   input_term_pulse_1_reg;
  logic [7:0]   input_term_pulse_2_reg;
  logic [7:0]   receive_equalizer_1_reg;
  logic [7:0]   receive_equalizer_2_reg;
  logic [7:0]   transmitter_settings_reg;
  logic [7:0]   rdata_next;
  logic [15:0]  pulse_canon;
  logic [15:0]  sel_old;
  logic [15:0]  sel_new;
  logic [15:0]  changed;
  logic [15:0]  pending_reg;
  logic [15:0]  pending_next;
  logic [`TERM_CNT_W-1:0] cnt_reg;
  logic [`TERM_CNT_W-1:0] cnt_next;
  logic         cnt_done;
  logic         trigger;
  logic         wr_hs;
  logic         wr_aux;
  logic         term_enable;
  logic [15:0]  term_next;
  pulse_state_t state_reg;
  pulse_state_t state_next;

  // Write strobes per register
  wire wr_rx  = i_reg_req.wr && (i_reg_req.addr == `ADDR_RX_SETTINGS);
  wire wr_pt1 = i_reg_req.wr && (i_reg_req.addr == `ADDR_TERM_PULSE_1);
  wire wr_pt2 = i_reg_req.wr && (i_reg_req.addr == `ADDR_TERM_PULSE_2);
  wire wr_eq1 = i_reg_req.wr && (i_reg_req.addr == `ADDR_RX_EQ_1);
  wire wr_eq2 = i_reg_req.wr && (i_reg_req.addr == `ADDR_RX_EQ_2);
  wire wr_tx  = i_reg_req.wr && (i_reg_req.addr == `ADDR_TX_SETTINGS);
  assign wr_hs  = i_reg_req.wr && (i_reg_req.addr == `ADDR_HS_MODES);
  assign wr_aux = i_reg_req.wr && (i_reg_req.addr == `ADDR_AUX_MODES);

  // Mode code 11 keeps the previous mode, other fields still written
  wire hs_mode_ok  = i_reg_req.wdata[`FLD_MODE_HI:`FLD_MODE_LO] != MODE_ILLEGAL;
  assign hs_modes_next = !wr_hs ? hs_modes_reg :
                         hs_mode_ok ? i_reg_req.wdata :
                         {i_reg_req.wdata[7:6], hs_modes_reg[5:4], i_reg_req.wdata[3:0]}; // R14
  assign aux_modes_next = !wr_aux ? aux_modes_reg :
                          (i_reg_req.wdata[`FLD_MODE_HI:`FLD_MODE_LO] != MODE_ILLEGAL) ? i_reg_req.wdata :
                          {i_reg_req.wdata[7:6], aux_modes_reg[5:4], i_reg_req.wdata[3:0]}; // R14

  // Read multiplexer, unmapped addresses read zero
  assign rdata_next = (i_reg_req.addr == `ADDR_HS_MODES)     ? hs_modes_reg :
                      (i_reg_req.addr == `ADDR_AUX_MODES)    ? aux_modes_reg :
                      (i_reg_req.addr == `ADDR_RX_SETTINGS)  ? receiver_settings_reg :
                      (i_reg_req.addr == `ADDR_TERM_PULSE_1) ? input_term_pulse_1_reg :
                      (i_reg_req.addr == `ADDR_TERM_PULSE_2) ? input_term_pulse_2_reg :
                      (i_reg_req.addr == `ADDR_RX_EQ_1)      ? receive_equalizer_1_reg :
                      (i_reg_req.addr == `ADDR_RX_EQ_2)      ? receive_equalizer_2_reg :
                      (i_reg_req.addr == `ADDR_TX_SETTINGS)  ? transmitter_settings_reg :
                      (i_reg_req.addr == `ADDR_STATUS)       ? {7'h00, state_reg == PT_HOLD} :
                      8'h00;

  // Register storage and read data
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hs_modes_reg             <= `RST_HS_MODES;
      aux_modes_reg            <= `RST_AUX_MODES;
      receiver_settings_reg    <= `RST_RX_SETTINGS;
      input_term_pulse_1_reg   <= `RST_TERM_PULSE;
      input_term_pulse_2_reg   <= `RST_TERM_PULSE;
      receive_equalizer_1_reg  <= `RST_RX_EQ;
      receive_equalizer_2_reg  <= `RST_RX_EQ;
      transmitter_settings_reg <= `RST_TX_SETTINGS;
      o_reg_rdata              <= 8'h00;
    end else begin
      hs_modes_reg  <= hs_modes_next;
      aux_modes_reg <= aux_modes_next;
      if (wr_rx)  receiver_settings_reg    <= {7'h00, i_reg_req.wdata[`FLD_TERM_EN]};
      if (wr_pt1) input_term_pulse_1_reg   <= i_reg_req.wdata;
      if (wr_pt2) input_term_pulse_2_reg   <= i_reg_req.wdata;
      if (wr_eq1) receive_equalizer_1_reg  <= i_reg_req.wdata;
      if (wr_eq2) receive_equalizer_2_reg  <= i_reg_req.wdata;
      if (wr_tx)  transmitter_settings_reg <= {4'h0, i_reg_req.wdata[3:0]};
      if (i_reg_req.rd) o_reg_rdata <= rdata_next;
    end
  end

  // --------------------------------------------------------------------------
  // Termination pulsing
  // --------------------------------------------------------------------------

  // Pulse bits in channel order and selection change detect
  assign pulse_canon = to_channel_order({input_term_pulse_2_reg, input_term_pulse_1_reg}); // R10
  assign sel_old     = hs_mask(hs_modes_reg);
  assign sel_new     = hs_mask(hs_modes_next);
  assign changed     = sel_old ^ sel_new; // R17
  assign trigger     = wr_hs && (changed & pulse_canon) != 16'h0000; // R08 R09
  assign cnt_done    = cnt_reg == `TERM_CNT_W'(TERM_PULSE_CYCLES - 1);
  assign term_enable = receiver_settings_reg[`FLD_TERM_EN];

  // Timer next state; a new change restarts the shared interval
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    pending_next = pending_reg;
    case (state_reg)
      PT_IDLE: begin
        if (trigger) begin
          state_next   = PT_HOLD;
          cnt_next     = '0;
          pending_next = changed & pulse_canon;
        end
      end
      PT_HOLD: begin
        if (trigger) begin
          cnt_next     = '0; // R16
          pending_next = pending_reg | (changed & pulse_canon);
        end else if (cnt_done) begin
          state_next   = PT_IDLE;
          pending_next = 16'h0000;
        end else begin
          cnt_next = cnt_reg + `TERM_CNT_W'(1); // R16
        end
      end
      default: begin
        state_next   = PT_IDLE;
        pending_next = 16'h0000;
      end
    endcase
  end

  // Connected unless disabled or pulsed inside a disconnect interval
  assign term_next = (state_next == PT_HOLD) ? ({16{term_enable}} & ~pending_next) : {16{term_enable}}; // R07 R09

  // Timer and output flip-flops
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg      <= PT_IDLE;
      cnt_reg        <= '0;
      pending_reg    <= 16'h0000;
      o_term_connect <= 16'h0000;
      o_aux_connect  <= '0;
      o_hs_select    <= 16'h0000;
      o_eq_high      <= 16'h0000;
      o_preemph_level <= 2'b00;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      pending_reg    <= pending_next;
      o_term_connect <= term_next;
      o_aux_connect  <= aux_route(aux_modes_next);
      o_hs_select    <= sel_new;
      o_eq_high      <= to_channel_order({receive_equalizer_2_reg, receive_equalizer_1_reg}); // R11 R12
      o_preemph_level <= transmitter_settings_reg[`FLD_PREEMPH_HI:`FLD_PREEMPH_LO]; // R13
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  wire aux_dual   = aux_modes_reg[`FLD_MODE_EN] && aux_modes_reg[5:4] == MODE_DUAL;
  wire aux_single = aux_modes_reg[`FLD_MODE_EN] && aux_modes_reg[5:4] == MODE_SINGLE;

  a_dual_top_ignored: assert property ( // R01
    $rose(i_rst_n) or !aux_dual or (o_aux_connect[0] == o_aux_connect[1] && o_aux_connect[0][15:8] == 8'h00))
    else $error("dual mode top select bit changed routing");
  // Routing flops load from the same next value as the mode register
  a_dual_ac_route: assert property ( // R02
    aux_dual && !aux_modes_reg[2] |-> o_aux_connect[0] == (16'h0001 << aux_modes_reg[1:0])
      && o_aux_connect[2] == (16'h0100 << aux_modes_reg[1:0]))
    else $error("dual mode A/C routing wrong");
  a_dual_bd_route: assert property ( // R03
    aux_dual && aux_modes_reg[2] |-> o_aux_connect[1] == (16'h0010 << aux_modes_reg[1:0])
      && o_aux_connect[3] == (16'h1000 << aux_modes_reg[1:0]))
    else $error("dual mode B/D routing wrong");
  a_single_onehot: assert property ( // R04
    aux_single |-> $onehot(o_aux_connect[0]) && o_aux_connect[3] == o_aux_connect[0])
    else $error("single mode not exactly one channel");
  a_single_order: assert property ( // R05 R06
    aux_single |-> o_aux_connect[0][aux_modes_reg[3:0]])
    else $error("single mode picked wrong channel");
  a_mode_retained: assert property ( // R14
    wr_aux && i_reg_req.wdata[5:4] == 2'b11 |=> aux_modes_reg[5:4] == $past(aux_modes_reg[5:4]))
    else $error("illegal mode code was stored");
  a_aux_disabled: assert property ( // R15
    !aux_modes_reg[`FLD_MODE_EN] && !wr_aux |=> o_aux_connect == '0)
    else $error("auxiliary lines connected while disabled");
  a_term_off: assert property ( // R07
    !term_enable && !wr_rx |=> o_term_connect == 16'h0000)
    else $error("termination connected while disabled");
  a_pulse_hold: assert property ( // R09
    state_reg == PT_HOLD && !trigger && !cnt_done |=> (o_term_connect & pending_reg) == 16'h0000)
    else $error("pulsed channel reconnected early");
  a_pulse_end: assert property ( // R16
    state_reg == PT_HOLD && cnt_done && !trigger && !wr_rx |=> state_reg == PT_IDLE
      && o_term_connect == {16{term_enable}})
    else $error("disconnect interval did not end");
  a_no_pulse_bit: assert property ( // R08
    wr_hs && (changed & pulse_canon) == 16'h0000 && state_reg == PT_IDLE |=> state_reg == PT_IDLE)
    else $error("interval started without pulse bit");
  a_preemph_all: assert property ( // R13
    ##1 o_preemph_level == $past(transmitter_settings_reg[3:2]))
    else $error("pre-emphasis level mismatch");
  a_eq_map: assert property ( // R12
    ##1 o_eq_high[0] == $past(receive_equalizer_1_reg[4]) && o_eq_high[8] == $past(receive_equalizer_2_reg[3]))
    else $error("equalizer bit mapping wrong");

  // Register field checks
  a_hs_mode_kept: assert property ( // R14
    wr_hs && i_reg_req.wdata[`FLD_MODE_HI:`FLD_MODE_LO] == 2'b11
      |=> hs_modes_reg[`FLD_MODE_HI:`FLD_MODE_LO] == $past(hs_modes_reg[`FLD_MODE_HI:`FLD_MODE_LO]))
    else $error("illegal high speed mode code was stored");
  a_eq_level: assert property ( // R11
    ##1 o_eq_high[15] == $past(receive_equalizer_2_reg[4])
      && o_eq_high[4] == $past(receive_equalizer_1_reg[0]))
    else $error("equalizer level bit lost");
  a_aux_off_write: assert property ( // R15
    wr_aux && !i_reg_req.wdata[`FLD_MODE_EN] |=> o_aux_connect == '0)
    else $error("auxiliary lines connected after disable write");

  // Termination pulse checks
  a_pulse_start: assert property ( // R09
    trigger |=> state_reg == PT_HOLD && cnt_reg == '0)
    else $error("disconnect interval did not start");
  a_pulse_map: assert property ( // R10
    state_reg == PT_IDLE && trigger && term_enable
      |=> o_term_connect[3:0] == ~($past(input_term_pulse_1_reg[7:4]) & $past(changed[3:0]))
      && o_term_connect[11] == !($past(input_term_pulse_2_reg[0]) && $past(changed[11])))
    else $error("pulse bit mapped to wrong channel");
  a_idle_connected: assert property ( // R07 R08
    state_reg == PT_IDLE && !trigger && term_enable && !wr_rx |=> o_term_connect == 16'hFFFF)
    else $error("termination dropped without a pulse");
  a_hold_bound: assert property ( // R16
    state_reg == PT_HOLD |-> cnt_reg < `TERM_CNT_W'(TERM_PULSE_CYCLES))
    else $error("disconnect counter overran");
  a_status_flag: assert property ( // R09
    i_reg_req.rd && i_reg_req.addr == `ADDR_STATUS |=> o_reg_rdata == {7'h00, $past(state_reg) == PT_HOLD})
    else $error("interval status bit wrong");

endmodule : aux_route_and_link_tuning_regs

// ### verilog/aux_route_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef AUX_ROUTE_MAP_SVH
`define AUX_ROUTE_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_HS_MODES      8'h10
`define ADDR_AUX_MODES     8'h11
`define ADDR_RX_SETTINGS   8'h12
`define ADDR_TERM_PULSE_1  8'h13
`define ADDR_TERM_PULSE_2  8'h14
`define ADDR_RX_EQ_1       8'h15
`define ADDR_RX_EQ_2       8'h16
`define ADDR_TX_SETTINGS   8'h17
`define ADDR_STATUS        8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FLD_MODE_EN        6
`define FLD_MODE_HI        5
`define FLD_MODE_LO        4
`define FLD_SEL_HI         3
`define FLD_SEL_LO         0
`define FLD_TERM_EN        0
`define FLD_PREEMPH_HI     3
`define FLD_PREEMPH_LO     2
`define FLD_STAT_PULSE     0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_HS_MODES       8'h00
`define RST_AUX_MODES      8'h40
`define RST_RX_SETTINGS    8'h01
`define RST_TERM_PULSE     8'h00
`define RST_RX_EQ          8'h00
`define RST_TX_SETTINGS    8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_KHZ            200000
`define TERM_PULSE_MS      100
`define TERM_PULSE_CYCLES  (`TERM_PULSE_MS * `CLK_KHZ)
`define TERM_CNT_W         25

`endif

// ### verilog/aux_route_pkg.sv
// Types shared by the auxiliary routing and link tuning registers
package aux_route_pkg;

  // Bundling mode of a switch
  typedef enum logic [1:0] {
    MODE_QUAD    = 2'b00,
    MODE_DUAL    = 2'b01,
    MODE_SINGLE  = 2'b10,
    MODE_ILLEGAL = 2'b11
  } bundle_mode_t;

  // Termination pulse timer state
  typedef enum logic [0:0] {
    PT_IDLE = 1'b0,
    PT_HOLD = 1'b1
  } pulse_state_t;

  // Register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Common line to auxiliary channel connection matrix
  typedef logic [3:0][15:0] aux_matrix_t;

endpackage : aux_route_pkg
